// file: src/dtq_top.sv
// Delayed trigger qualifier: holds delayed trigger configuration and qualifies its firing.
// Assumes the command decoder (including the alias command set) presents one-cycle write
// strobes, and that comparator outputs per source arrive asynchronously on pins.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module dtq_top
   import dtq_pkg::*;
#(
   parameter int DTQ_TIME_MAX_NS = 1_000_000
)
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_wr_valid,
   input wire dtq_field_t i_wr_field,
   input wire logic [31:0] i_wr_data,
   input wire logic i_level_valid,
   input wire dtq_level_cmd_t i_level_cmd,
   input wire logic signed [15:0] i_level_mv,
   input wire logic signed [15:0] i_src_max_mv,
   input wire logic signed [15:0] i_src_min_mv,
   input wire logic [6:0] i_cmp_above,
   input wire logic i_main_fired,
   input wire logic i_main_rearm,
   output logic o_state,
   output dtq_method_t o_method,
   output dtq_coupling_t o_coupling,
   output dtq_source_t o_source,
   output dtq_slope_t o_slope,
   output logic [10:0] o_edge_readback,
   output logic [15:0] o_event_count,
   output logic [31:0] o_delay_time_ns,
   output logic signed [15:0] o_level_mv,
   output logic [7:0] o_aux_probe_gain,
   output logic o_armed,
   output logic o_delayed_fire
);

   typedef enum logic [1:0] {
      DTQ_IDLE,
      DTQ_WAIT,
      DTQ_ARMED,
      DTQ_DONE
   } dtq_phase_t;

   typedef struct packed {
      logic state;
      dtq_method_t method;
      dtq_coupling_t coupling;
      dtq_source_t source;
      dtq_slope_t slope;
      logic [15:0] count;
      logic [31:0] time_ns;
      logic signed [15:0] level;
      logic [7:0] gain;
      dtq_phase_t phase;
      logic [15:0] ev_cnt;
      logic [31:0] tmr_ns;
      logic prev_above;
      logic fire;
   } dtq_state_t;

   dtq_state_t st_reg;
   dtq_state_t st_next;
   logic [6:0] above_sync;
   logic above;
   logic crossing;
   logic signed [16:0] mid_sum;

   dtq_sync #(.WIDTH(7)) u_sync (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_async(i_cmp_above),
      .o_sync(above_sync)
   );

   // Coupling code mapping, AC folds into low-frequency reject
   function automatic dtq_coupling_t dtq_map_coupling(input logic [2:0] code);
      dtq_coupling_t c;
      c = DTQ_CPL_DC;
      unique case (dtq_coupling_wr_t'(code))
         DTQ_CPLW_DC: c = DTQ_CPL_DC;
         DTQ_CPLW_HIGH_FREQ_REJECT: c = DTQ_CPL_HIGH_FREQ_REJECT;
         DTQ_CPLW_LOW_FREQ_REJECT: c = DTQ_CPL_LOW_FREQ_REJECT;
         DTQ_CPLW_LOW_SENSITIVITY_REJECT: c = DTQ_CPL_LOW_SENSITIVITY_REJECT;
         DTQ_CPLW_AC: c = DTQ_CPL_LOW_FREQ_REJECT;
         default: c = DTQ_CPL_DC;
      endcase
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Event detection on the selected source
   always_comb
   begin
      above = above_sync[st_reg.source];
      if (st_reg.slope == DTQ_SLOPE_FALL)
      begin
         crossing = st_reg.prev_above && !above;
      end
      else
      begin
         crossing = !st_reg.prev_above && above;
      end
      mid_sum = 17'(i_src_max_mv) + 17'(i_src_min_mv);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration writes and delay sequencing
   always_comb
   begin
      st_next = st_reg;
      st_next.prev_above = above;
      st_next.fire = 1'b0;
      // Alias commands are decoded to the same field codes upstream
      if (i_wr_valid)
      begin
         unique case (i_wr_field)
            DTQ_FLD_STATE: st_next.state = i_wr_data[0];
            DTQ_FLD_METHOD: st_next.method = dtq_method_t'(i_wr_data[0]);
            DTQ_FLD_COUPLING: st_next.coupling = dtq_map_coupling(i_wr_data[2:0]);
            DTQ_FLD_SLOPE: st_next.slope = dtq_slope_t'(i_wr_data[0]);
            DTQ_FLD_SOURCE:
            begin
               // Unknown source codes are ignored to keep the mux in range
               if (i_wr_data[2:0] <= 3'(DTQ_SRC_ATTENUATED_AUX_INPUT))
               begin
                  st_next.source = dtq_source_t'(i_wr_data[2:0]);
               end
            end
            DTQ_FLD_COUNT: st_next.count = i_wr_data[15:0];
            DTQ_FLD_TIME:
            begin
               // Clamped so the timer always terminates
               if (i_wr_data > 32'(DTQ_TIME_MAX_NS))
               begin
                  st_next.time_ns = 32'(DTQ_TIME_MAX_NS);
               end
               else
               begin
                  st_next.time_ns = i_wr_data;
               end
            end
            DTQ_FLD_GAIN: st_next.gain = i_wr_data[7:0];
         endcase
      end
      if (i_level_valid)
      begin
         unique case (i_level_cmd)
            DTQ_LVL_VOLTS: st_next.level = i_level_mv;
            DTQ_LVL_ECL: st_next.level = DTQ_LEVEL_ECL_MV;
            DTQ_LVL_TTL: st_next.level = DTQ_LEVEL_TTL_MV;
            DTQ_LVL_HALF_AMPLITUDE: st_next.level = mid_sum[16:1];
         endcase
      end

      if (i_main_rearm)
      begin
         st_next.phase = DTQ_IDLE;
         st_next.ev_cnt = '0;
         st_next.tmr_ns = '0;
      end
      else
      begin
         unique case (st_reg.phase)
            DTQ_IDLE:
            begin
               if (i_main_fired)
               begin
                  if (!st_reg.state)
                  begin
                     st_next.fire = 1'b1;
                     st_next.phase = DTQ_DONE;
                  end
                  else if (st_reg.method == DTQ_BY_TIME)
                  begin
                     st_next.phase = DTQ_WAIT;
                     st_next.tmr_ns = '0;
                  end
                  else
                  begin
                     st_next.phase = DTQ_ARMED;
                     st_next.ev_cnt = '0;
                  end
               end
            end
            DTQ_WAIT:
            begin
               if (st_reg.tmr_ns + 32'(DTQ_CLK_PERIOD_NS) >= st_reg.time_ns)
               begin
                  st_next.phase = DTQ_ARMED;
               end
               else
               begin
                  st_next.tmr_ns = st_reg.tmr_ns + 32'(DTQ_CLK_PERIOD_NS);
               end
            end
            DTQ_ARMED:
            begin
               if (crossing)
               begin
                  if (st_reg.method == DTQ_BY_TIME)
                  begin
                     st_next.fire = 1'b1;
                     st_next.phase = DTQ_DONE;
                  end
                  else if (st_reg.ev_cnt + 16'h0001 >= st_reg.count)
                  begin
                     st_next.fire = 1'b1;
                     st_next.phase = DTQ_DONE;
                     st_next.ev_cnt = st_reg.ev_cnt + 16'h0001;
                  end
                  else
                  begin
                     st_next.ev_cnt = st_reg.ev_cnt + 16'h0001;
                  end
               end
            end
            DTQ_DONE:
            begin
               st_next.phase = DTQ_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st_reg <= '{state: DTQ_RST_STATE, method: DTQ_BY_TIME, coupling: DTQ_CPL_DC,
                     source: DTQ_SRC_CH1, slope: DTQ_SLOPE_RISE, count: DTQ_RST_COUNT,
                     time_ns: DTQ_RST_TIME_NS, level: DTQ_RST_LEVEL, gain: DTQ_RST_GAIN,
                     phase: DTQ_IDLE, ev_cnt: 16'h0000, tmr_ns: 32'h0000_0000,
                     prev_above: 1'b0, fire: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Readback
   assign o_state = st_reg.state;
   assign o_method = st_reg.method;
   assign o_coupling = st_reg.coupling;
   assign o_source = st_reg.source;
   assign o_slope = st_reg.slope;
   assign o_edge_readback = {5'h00, st_reg.coupling, st_reg.source, st_reg.slope};
   assign o_event_count = st_reg.count;
   assign o_delay_time_ns = st_reg.time_ns;
   assign o_level_mv = st_reg.level;
   assign o_aux_probe_gain = st_reg.gain;
   assign o_armed = (st_reg.phase == DTQ_ARMED);
   assign o_delayed_fire = st_reg.fire;

endmodule

`default_nettype wire

// file: src/dtq_pkg.sv
// Package for the delayed trigger qualifier: encodings, field widths, presets and reset values.
// Assumes a 25 MHz system clock and levels carried as signed millivolts.
package dtq_pkg;

   localparam int DTQ_CLK_HZ = 25_000_000;
   localparam int DTQ_CLK_PERIOD_NS = 40;
   localparam int DTQ_CNT_W = 16;
   localparam int DTQ_TIME_W = 32;
   localparam int DTQ_LEVEL_W = 16;
   localparam int DTQ_GAIN_W = 8;
   localparam int DTQ_SYNC_DEPTH = 3;

   typedef enum logic [1:0] {
      DTQ_CPL_DC,
      DTQ_CPL_HIGH_FREQ_REJECT,
      DTQ_CPL_LOW_FREQ_REJECT,
      DTQ_CPL_LOW_SENSITIVITY_REJECT
   } dtq_coupling_t;

   // Write-side code set includes the AC synonym
   typedef enum logic [2:0] {
      DTQ_CPLW_DC,
      DTQ_CPLW_HIGH_FREQ_REJECT,
      DTQ_CPLW_LOW_FREQ_REJECT,
      DTQ_CPLW_LOW_SENSITIVITY_REJECT,
      DTQ_CPLW_AC
   } dtq_coupling_wr_t;

   typedef enum logic [2:0] {
      DTQ_SRC_CH1,
      DTQ_SRC_CH2,
      DTQ_SRC_CH3,
      DTQ_SRC_CH4,
      DTQ_SRC_MAINS,
      DTQ_SRC_AUX_TRIGGER_INPUT,
      DTQ_SRC_ATTENUATED_AUX_INPUT
   } dtq_source_t;

   typedef enum logic {
      DTQ_SLOPE_RISE,
      DTQ_SLOPE_FALL
   } dtq_slope_t;

   typedef enum logic {
      DTQ_BY_TIME,
      DTQ_BY_EVENTS
   } dtq_method_t;

   typedef enum logic [1:0] {
      DTQ_LVL_VOLTS,
      DTQ_LVL_ECL,
      DTQ_LVL_TTL,
      DTQ_LVL_HALF_AMPLITUDE
   } dtq_level_cmd_t;

   typedef enum logic [2:0] {
      DTQ_FLD_STATE,
      DTQ_FLD_METHOD,
      DTQ_FLD_COUPLING,
      DTQ_FLD_SLOPE,
      DTQ_FLD_SOURCE,
      DTQ_FLD_COUNT,
      DTQ_FLD_TIME,
      DTQ_FLD_GAIN
   } dtq_field_t;

   // Level presets in millivolts
   localparam logic signed [15:0] DTQ_LEVEL_ECL_MV = -16'sd1300;
   localparam logic signed [15:0] DTQ_LEVEL_TTL_MV = 16'sd1400;

   localparam logic DTQ_RST_STATE = 1'b0;
   localparam logic [15:0] DTQ_RST_COUNT = 16'h0001;
   localparam logic [31:0] DTQ_RST_TIME_NS = 32'h0000_0000;
   localparam logic signed [15:0] DTQ_RST_LEVEL = 16'sh0000;
   localparam logic [7:0] DTQ_RST_GAIN = 8'h01;

endpackage

// file: src/dtq_sync.sv
// Three-stage synchroniser with an agreement filter for a vector of pin inputs.
// Assumes the inputs are asynchronous to i_mclk.
`timescale 1ns/100ps
`default_nettype none

module dtq_sync
   import dtq_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } dtq_sync_state_t;

   dtq_sync_state_t st_reg;
   dtq_sync_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = i_async;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // A change counts only once stages two and three agree
      for (int i = 0; i < WIDTH; i++)
      begin
         if (st_reg.s2[i] == st_reg.s3[i])
         begin
            st_next.out[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_sync = st_reg.out;

endmodule

`default_nettype wire

// file: tb/dtq_top_monitor.sv
// Checker for the delayed trigger qualifier, watching only the top ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module dtq_top_monitor
   import dtq_pkg::*;
#(
   parameter int DTQ_TIME_MAX_NS = 1_000_000
)
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_wr_valid,
   input wire dtq_field_t i_wr_field,
   input wire logic [31:0] i_wr_data,
   input wire logic i_level_valid,
   input wire dtq_level_cmd_t i_level_cmd,
   input wire logic signed [15:0] i_src_max_mv,
   input wire logic signed [15:0] i_src_min_mv,
   input wire logic i_main_fired,
   input wire logic i_main_rearm,
   input wire logic o_state,
   input wire dtq_method_t o_method,
   input wire dtq_coupling_t o_coupling,
   input wire dtq_source_t o_source,
   input wire dtq_slope_t o_slope,
   input wire logic [10:0] o_edge_readback,
   input wire logic [15:0] o_event_count,
   input wire logic [31:0] o_delay_time_ns,
   input wire logic signed [15:0] o_level_mv,
   input wire logic o_armed,
   input wire logic o_delayed_fire
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////
   // Tracks whether a main trigger may be taken
   logic idle_reg;
   always_ff @(posedge i_mclk)
      idle_reg <= i_reset | i_main_rearm | (idle_reg & ~i_main_fired);

   property p_state;
      i_wr_valid && i_wr_field == DTQ_FLD_STATE |=> o_state == $past(i_wr_data[0]);
   endproperty
   a_state: assert property (p_state) else $error("state write lost");
   property p_ac;
      i_wr_valid && i_wr_field == DTQ_FLD_COUPLING && i_wr_data[2:0] == 3'h4
      |=> o_coupling == DTQ_CPL_LOW_FREQ_REJECT;
   endproperty
   a_ac: assert property (p_ac) else $error("ac not stored as lf reject");
   property p_edge;
      o_edge_readback == {5'h00, o_coupling, o_source, o_slope};
   endproperty
   a_edge: assert property (p_edge) else $error("edge readback wrong");
   property p_count;
      i_wr_valid && i_wr_field == DTQ_FLD_COUNT |=> o_event_count == $past(i_wr_data[15:0]);
   endproperty
   a_count: assert property (p_count) else $error("count write lost");
   property p_time;
      i_wr_valid && i_wr_field == DTQ_FLD_TIME |=> o_delay_time_ns ==
      (($past(i_wr_data) > DTQ_TIME_MAX_NS) ? DTQ_TIME_MAX_NS : $past(i_wr_data));
   endproperty
   a_time: assert property (p_time) else $error("delay time wrong");
   property p_ecl;
      i_level_valid && i_level_cmd == DTQ_LVL_ECL |=> o_level_mv == DTQ_LEVEL_ECL_MV;
   endproperty
   a_ecl: assert property (p_ecl) else $error("ecl preset wrong");
   // The sum is widened first so that large source swings cannot overflow
   property p_half;
      i_level_valid && i_level_cmd == DTQ_LVL_HALF_AMPLITUDE |=>
      o_level_mv == 16'((17'($past(i_src_max_mv)) + 17'($past(i_src_min_mv))) >>> 1);
   endproperty
   a_half: assert property (p_half) else $error("half level wrong");
   property p_bypass;
      idle_reg && i_main_fired && !i_main_rearm && !o_state |=> o_delayed_fire;
   endproperty
   a_bypass: assert property (p_bypass) else $error("no pass through");
   // A crossing or a rearm in the first armed cycle may legally end the armed phase
   property p_arm;
      idle_reg && i_main_fired && !i_main_rearm && o_state && o_method == DTQ_BY_EVENTS
      |=> o_armed ##1 (o_armed || o_delayed_fire || $past(i_main_rearm));
   endproperty
   a_arm: assert property (p_arm) else $error("events not armed");
   property p_rearm;
      i_main_rearm |=> !o_armed && !o_delayed_fire;
   endproperty
   a_rearm: assert property (p_rearm) else $error("rearm did not clear");
endmodule

bind dtq_top dtq_top_monitor #(.DTQ_TIME_MAX_NS(DTQ_TIME_MAX_NS)) u_mon (.i_mclk, .i_reset,
   .i_wr_valid, .i_wr_field, .i_wr_data, .i_level_valid, .i_level_cmd, .i_src_max_mv,
   .i_src_min_mv, .i_main_fired, .i_main_rearm, .o_state, .o_method, .o_coupling, .o_source,
   .o_slope, .o_edge_readback, .o_event_count, .o_delay_time_ns, .o_level_mv, .o_armed,
   .o_delayed_fire);
`default_nettype wire

// file: tb/dtq_ctrl_model.sv
// Controller model: issues one-cycle configuration write strobes.
// Assumes the bench calls its tasks at one time after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module dtq_ctrl_model
   import dtq_pkg::*;
(
   input wire logic i_mclk,
   output logic o_wr_valid,
   output dtq_field_t o_wr_field,
   output logic [31:0] o_wr_data
);
   initial
   begin
      o_wr_valid = 1'b0;
      o_wr_field = DTQ_FLD_STATE;
      o_wr_data = 32'h0;
   end
   ////////////////////////////////////////
   task send(input dtq_field_t f, input logic [31:0] d);
      @(posedge i_mclk);
      #1;
      o_wr_valid = 1'b1;
      o_wr_field = f;
      o_wr_data = d;
      @(posedge i_mclk);
      #1;
      o_wr_valid = 1'b0;
      // Stale data is inverted so nothing can rely on it
      o_wr_data = ~d;
   endtask
   // The device cannot sense the probe, so gain is always written
   task set_gain(input logic [7:0] g);
      send(DTQ_FLD_GAIN, {24'h0, g});
   endtask
endmodule
`default_nettype wire

// file: tb/dtq_top_bench.sv
// Self-checking bench for the delayed trigger qualifier.
// Assumes dtq_ctrl_model drives the configuration write side.
`timescale 1ns/100ps
`default_nettype none

module dtq_top_bench
   import dtq_pkg::*;
;
   localparam int TMAX = 400;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic lv = 1'b0;
   logic mf = 1'b0;
   logic rr = 1'b0;
   logic wv;
   dtq_field_t wf;
   logic [31:0] wd;
   dtq_level_cmd_t lc = DTQ_LVL_VOLTS;
   logic signed [15:0] lmv = 16'sh01F4;
   logic signed [15:0] smax = 16'sh07D0;
   logic signed [15:0] smin = -16'sh0258;
   logic [6:0] cmp = 7'h00;
   logic st, arm, fire;
   dtq_method_t meth;
   dtq_coupling_t cpl;
   dtq_source_t src;
   dtq_slope_t slp;
   logic [10:0] erb;
   logic [15:0] ecnt;
   logic [31:0] dly;
   logic signed [15:0] lvl;
   logic [7:0] gain;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   int f, a;
   always #20 clk = ~clk;
   dtq_ctrl_model u_ctrl (.i_mclk(clk), .o_wr_valid(wv), .o_wr_field(wf), .o_wr_data(wd));
   dtq_top #(.DTQ_TIME_MAX_NS(TMAX)) DUT (.i_mclk(clk), .i_reset(rst), .i_wr_valid(wv),
      .i_wr_field(wf), .i_wr_data(wd), .i_level_valid(lv), .i_level_cmd(lc),
      .i_level_mv(lmv), .i_src_max_mv(smax), .i_src_min_mv(smin), .i_cmp_above(cmp),
      .i_main_fired(mf), .i_main_rearm(rr), .o_state(st), .o_method(meth),
      .o_coupling(cpl), .o_source(src), .o_slope(slp), .o_edge_readback(erb),
      .o_event_count(ecnt), .o_delay_time_ns(dly), .o_level_mv(lvl),
      .o_aux_probe_gain(gain), .o_armed(arm), .o_delayed_fire(fire));
   ////////////////////////////////////////
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         miscompares++;
         give_verdict;
      end
   end
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task pulse_main(input logic re);
      // Only the strobe raised here is lowered, so back-to-back calls never redrive it
      if (re)
      begin
         rr = 1'b1;
         step(1);
         rr = 1'b0;
      end
      else
      begin
         mf = 1'b1;
         step(1);
         mf = 1'b0;
      end
   endtask
   // Comparator levels held long enough to pass the pin synchroniser
   task run(input logic [6:0] v, input int n);
      cmp = v;
      f = 0;
      a = 0;
      repeat (n)
      begin
         step(1);
         f += (fire === 1'b1);
         a += (arm === 1'b1);
      end
   endtask
   ////////////////////////////////////////
   task t_reset;
      chk("state", st, 32'h0);
      chk("count", ecnt, 32'h1);
      chk("coupling", cpl, 32'h0);
      chk("gain", gain, 32'h1);
      chk("armed", arm, 32'h0);
      chk("fire", fire, 32'h0);
   endtask
   task t_cfg;
      for (int k = 0; k < 8; k++)
      begin
         u_ctrl.send(DTQ_FLD_SOURCE, 32'(k));
         chk("source", src, (k == 7) ? 32'h6 : 32'(k));
      end
      u_ctrl.send(DTQ_FLD_SOURCE, 32'h2);
      u_ctrl.send(DTQ_FLD_SLOPE, 32'h1);
      chk("slope", slp, 32'h1);
      for (int k = 0; k < 5; k++)
      begin
         u_ctrl.send(DTQ_FLD_COUPLING, 32'(k));
         // Code 4 is the AC synonym and must read back as low-frequency reject
         chk("coupling", cpl, (k == 4) ? 32'h2 : 32'(k));
         chk("edge", 32'(erb), {26'h0, ((k == 4) ? 2'h2 : 2'(k)), 4'h5});
      end
      u_ctrl.send(DTQ_FLD_COUNT, 32'hFFFF);
      chk("count", ecnt, 32'hFFFF);
      u_ctrl.send(DTQ_FLD_TIME, 32'h3E8);
      chk("time", dly, 32'(TMAX));
      u_ctrl.send(DTQ_FLD_METHOD, 32'h1);
      chk("method", meth, 32'h1);
      u_ctrl.set_gain(8'h0A);
      chk("gain", gain, 32'hA);
   endtask
   task lvl_cmd(input dtq_level_cmd_t c, input logic [31:0] e);
      lc = c;
      lv = 1'b1;
      step(1);
      lv = 1'b0;
      chk("level", lvl, e);
      // Let an edge pass with the strobe low before the next command
      step(1);
   endtask
   task t_level;
      lvl_cmd(DTQ_LVL_VOLTS, 32'h1F4);
      lvl_cmd(DTQ_LVL_ECL, 32'hFFFF_FAEC);
      lvl_cmd(DTQ_LVL_TTL, 32'h578);
      lvl_cmd(DTQ_LVL_HALF_AMPLITUDE, 32'h2BC);
   endtask
   task t_bypass;
      u_ctrl.send(DTQ_FLD_STATE, 32'h0);
      pulse_main(1'b1);
      pulse_main(1'b0);
      chk("fire", fire, 32'h1);
      step(1);
      chk("fire", fire, 32'h0);
   endtask
   task t_events;
      u_ctrl.send(DTQ_FLD_STATE, 32'h1);
      chk("state", st, 32'h1);
      u_ctrl.send(DTQ_FLD_COUNT, 32'h2);
      u_ctrl.send(DTQ_FLD_SOURCE, 32'h1);
      u_ctrl.send(DTQ_FLD_SLOPE, 32'h0);
      pulse_main(1'b1);
      run(7'h02, 8);
      run(7'h00, 8);
      pulse_main(1'b0);
      chk("armed", arm, 32'h1);
      run(7'h02, 8);
      chk("early", f, 32'h0);
      run(7'h00, 8);
      chk("fall", f, 32'h0);
      run(7'h02, 10);
      chk("fire", f, 32'h1);
   endtask
   task t_time;
      u_ctrl.send(DTQ_FLD_METHOD, 32'h0);
      u_ctrl.send(DTQ_FLD_TIME, 32'(TMAX));
      u_ctrl.send(DTQ_FLD_SLOPE, 32'h1);
      u_ctrl.send(DTQ_FLD_SOURCE, 32'h4);
      pulse_main(1'b1);
      run(7'h10, 8);
      pulse_main(1'b0);
      run(7'h10, 8);
      chk("wait", a, 32'h0);
      // 400 ns at 40 ns a cycle: armed from the tenth edge, so three of these four
      run(7'h10, 4);
      chk("armed", a, 32'h3);
      run(7'h00, 10);
      chk("fire", f, 32'h1);
   endtask
   initial
   begin
      step(8);
      rst = 1'b0;
      t_reset;
      t_cfg;
      t_level;
      t_bypass;
      t_events;
      t_time;
      give_verdict;
   end
endmodule
`default_nettype wire
